// >>> rtl/lfd_pkg.sv
/*
 * Shared constants for the LF coil driver command executor and fault monitor:
 * LF timing, command opcodes, field positions and reset values.
 * Assumes a system clock from which one LF period is a fixed number of cycles.
 */
package lfd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // LF timing.
    localparam int unsigned LF_PERIOD_CLKS     = 64;
    localparam int unsigned BIT_PERIODS_NORMAL = 32;
    localparam int unsigned BIT_PERIODS_FAST   = 22;
    localparam int unsigned NORM_BIT_CLKS      = LF_PERIOD_CLKS * BIT_PERIODS_NORMAL;
    localparam int unsigned FAST_BIT_CLKS      = LF_PERIOD_CLKS * BIT_PERIODS_FAST;

    ////////////////////////////////////////////////////////////////////////////
    // Telegram store: one header word plus up to eight data words.
    localparam int unsigned TEL_WORDS = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Command words.
    localparam logic [2:0] OPC_SELECT      = 3'h1;
    localparam logic [2:0] OPC_CURRENT     = 3'h5;
    localparam logic [2:0] OPC_CARRIER     = 3'h4;
    localparam logic [3:0] OPC_DATA        = 4'h0;
    localparam logic [7:0] CMD_FAULT_CLEAR = 8'h40;
    localparam logic [7:0] CMD_STATUS_READ = 8'h60;
    localparam logic [7:0] CMD_SETUP_READ  = 8'h68;
    localparam logic [7:0] CMD_FAULT_READ  = 8'h70;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned SEL_RATE_BIT = 4;
    localparam int unsigned SEL_DIAG_BIT = 3;
    localparam int unsigned FR_CHAN_LSB  = 5;
    localparam int unsigned FR_TEMP_BIT  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [2:0] CHAN_RESET = 3'h1;
    localparam logic [4:0] CUR_RESET  = 5'h00;
    localparam logic       RATE_RESET = 1'b0;
    localparam logic       DIAG_RESET = 1'b0;

endpackage

// >>> rtl/lfd_bit_timer.sv
/*
 * LF bit timer: divides the system clock into LF periods and LF periods into
 * data bits, giving a one-cycle tick at the last cycle of each bit.
 * Assumes run stays high for the whole of a transmission; it restarts at zero.
 */
`timescale 1ns/10ps
module lfd_bit_timer
    import lfd_pkg::*;
#(
    parameter int unsigned PERIOD_CLKS  = LF_PERIOD_CLKS,
    parameter int unsigned NORM_PERIODS = BIT_PERIODS_NORMAL,
    parameter int unsigned FAST_PERIODS = BIT_PERIODS_FAST
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    input  wire logic fast,
    // Tick
    output logic      bit_tick
);

    localparam int unsigned CW = $clog2(PERIOD_CLKS);
    localparam int unsigned PW = $clog2(NORM_PERIODS);

    typedef struct packed {
        logic [CW-1:0] clk_cnt;
        logic [PW-1:0] per_cnt;
    } lfd_tmr_t;

    lfd_tmr_t        q;
    lfd_tmr_t        n;
    logic            period_end;
    logic [PW-1:0]   per_last;

    ////////////////////////////////////////////////////////////////////////////
    assign period_end = (q.clk_cnt == CW'(PERIOD_CLKS - 1));
    assign per_last   = fast ? PW'(FAST_PERIODS - 1) : PW'(NORM_PERIODS - 1);
    assign bit_tick   = run & period_end & (q.per_cnt == per_last);

    always_comb begin
        n = q;
        if (!run) begin
            n = '0;
        end else begin
            n.clk_cnt = period_end ? '0 : q.clk_cnt + 1'b1;
            if (period_end) begin
                n.per_cnt = (q.per_cnt == per_last) ? '0 : q.per_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule

// >>> rtl/lfd_core.sv
/*
 * LF coil driver command executor and fault monitor. Takes driver command
 * words from the link, steers the coil power stages, sends LF telegrams and
 * carrier bursts, and keeps the fault record, status and interrupt request.
 * Assumes words arrive on link_clk with a valid strobe, at most one per
 * link cycle, and that the analog monitor inputs are asynchronous levels.
 */
`timescale 1ns/10ps
module lfd_core
    import lfd_pkg::*;
(
    // Clocks and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       link_clk,
    // Command words from the link
    input  wire logic       word_valid,
    input  wire logic [7:0] word_data,
    // Monitored conditions, asynchronous
    input  wire logic       oscillator_stable,
    input  wire logic       analog_supply_ok,
    input  wire logic       driver_supply_ok,
    input  wire logic       thermal_shutdown,
    input  wire logic       missing_return_fault,
    input  wire logic       shunt_overvoltage_fault,
    input  wire logic       high_side_overcurrent_fault,
    input  wire logic       low_side_overcurrent_fault,
    // Power stage controls
    output logic [5:0]      coil_select,
    output logic            drive_enable,
    output logic            coil_drive,
    output logic [4:0]      current_step,
    output logic            line_diagnosis_enable,
    output logic            pos_test_switch,
    output logic            neg_test_switch,
    // Readback and status
    output logic            read_valid,
    output logic [7:0]      read_data,
    output logic            operability_flag,
    output logic            irq,
    output logic [7:0]      driver_fault_record
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PAY  = 4'h2,
        ST_DATA = 4'h4,
        ST_CARR = 4'h8
    } lfd_st_t;

    typedef struct packed {
        logic                       tog_s1;
        logic                       tog_s2;
        logic                       tog_s3;
        logic [4:0]                 flt_s1;
        logic [4:0]                 flt_s2;
        logic [2:0]                 sup_s1;
        logic [2:0]                 sup_s2;
        lfd_st_t                    st;
        logic                       bit_rate;
        logic                       diag;
        logic [2:0]                 chan;
        logic [4:0]                 cur;
        logic [7:0]                 rec;
        logic                       need_clear;
        logic                       op;
        logic                       irq;
        logic                       reset_seen;
        logic [3:0]                 pay_left;
        logic [3:0]                 pay_idx;
        logic                       pay_discard;
        logic [TEL_WORDS-1:0][7:0]  tel;
        logic [5:0]                 bit_cnt;
        logic [4:0]                 car_left;
        logic                       car_endless;
        logic [5:0]                 coil_select;
        logic                       drive_enable;
        logic                       coil_drive;
        logic                       pos_sw;
        logic                       neg_sw;
        logic                       read_valid;
        logic [7:0]                 read_data;
        logic [11:0]                gap;
    } lfd_core_t;

    typedef struct packed {
        logic       lrst_s1;
        logic       lrst_s2;
        logic       tog;
        logic [7:0] hold;
    } lfd_link_t;

    localparam logic [11:0] NORM_GAP = 12'(NORM_BIT_CLKS - 1);
    localparam logic [11:0] FAST_GAP = 12'(FAST_BIT_CLKS - 1);

    lfd_core_t   q;
    lfd_core_t   n;
    lfd_link_t   lq;
    lfd_link_t   ln;
    logic        comm_ok;
    logic        word_new;
    logic [7:0]  w;
    logic        tx_busy;
    logic        blocked;
    logic        drv_ok;
    logic        clr_now;
    logic        stat_now;
    logic [4:0]  fault_hit;
    logic        bit_tick;

    function automatic logic [5:0] chan_onehot(input logic [2:0] c);
        logic [2:0] pos;
        pos = {1'b0, c[1:0]} - 3'h1 + (c[2] ? 3'h3 : 3'h0);
        chan_onehot = (c[1:0] == 2'h0) ? 6'h00 : (6'h01 << pos);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: each word is held and announced by a toggle. The hold
    // register stays still for a whole link cycle, far longer than the
    // three system cycles the toggle needs to cross.
    always_comb begin
        ln = lq;
        ln.lrst_s1 = rst;
        ln.lrst_s2 = lq.lrst_s1;
        if (lq.lrst_s2) begin
            ln.tog  = 1'b0;
            ln.hold = 8'h00;
        end else if (word_valid) begin
            ln.tog  = ~lq.tog;
            ln.hold = word_data;
        end
    end

    always_ff @(posedge link_clk) begin
        lq <= ln;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word decode helpers.
    assign comm_ok  = q.sup_s2[2] & q.sup_s2[1];
    assign word_new = (q.tog_s2 != q.tog_s3) & comm_ok;
    assign w        = lq.hold;
    assign tx_busy  = (q.st == ST_DATA) || (q.st == ST_CARR);
    assign blocked  = tx_busy & ~((q.st == ST_CARR) & q.car_endless);
    assign drv_ok   = (q.op | (q.diag & (w[7:5] == OPC_SELECT))) & ~blocked;
    assign clr_now  = word_new & (q.st != ST_PAY) & (w == CMD_FAULT_CLEAR);
    assign stat_now = word_new & (q.st != ST_PAY) & (w == CMD_STATUS_READ);
    // Only new fault bits count, so a fault that persists raises one request.
    assign fault_hit = {q.flt_s2[4],
                        q.flt_s2[3] & q.drive_enable & q.coil_drive,
                        q.flt_s2[2:0] & {3{q.drive_enable}}} & ~q.rec[4:0];

    lfd_bit_timer u_timer (
        .mclk     (mclk),
        .rst      (rst),
        .run      (tx_busy),
        .fast     (q.bit_rate),
        .bit_tick (bit_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // System domain next state.
    always_comb begin
        logic [3:0] widx;
        widx = 4'h0;
        n = q;
        n.tog_s1 = lq.tog;
        n.tog_s2 = q.tog_s1;
        n.tog_s3 = q.tog_s2;
        n.flt_s1 = {thermal_shutdown, missing_return_fault, shunt_overvoltage_fault,
                    high_side_overcurrent_fault, low_side_overcurrent_fault};
        n.flt_s2 = q.flt_s1;
        n.sup_s1 = {oscillator_stable, analog_supply_ok, driver_supply_ok};
        n.sup_s2 = q.sup_s1;
        n.read_valid = 1'b0;

        case (q.st)
            ST_IDLE, ST_PAY: begin
                n.st = q.st;
            end
            ST_DATA: begin
                if (bit_tick) begin
                    if (q.bit_cnt == {q.tel[0][3:0], 2'b11}) begin
                        n.st = ST_IDLE;
                    end else begin
                        n.bit_cnt = q.bit_cnt + 6'h01;
                    end
                end
            end
            ST_CARR: begin
                if (bit_tick && !q.car_endless) begin
                    if (q.car_left == 5'h01) begin
                        n.st = ST_IDLE;
                    end else begin
                        n.car_left = q.car_left - 5'h01;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        if (word_new) begin
            if (q.st == ST_PAY) begin
                n.tel[q.pay_idx] = w;
                n.pay_idx  = q.pay_idx + 4'h1;
                n.pay_left = q.pay_left - 4'h1;
                if (q.pay_left == 4'h1) begin
                    n.st      = q.pay_discard ? ST_IDLE : ST_DATA;
                    n.bit_cnt = 6'h00;
                end
            end else if (clr_now) begin
                n.rec = 8'h00;
                if (!q.diag) begin
                    n.need_clear = 1'b0;
                end
            end else if (stat_now) begin
                n.read_data  = {q.reset_seen, |q.rec[3:0] | q.rec[FR_TEMP_BIT], 2'b00,
                                q.rec[FR_TEMP_BIT], q.bit_rate, q.op, 1'b0};
                n.read_valid = 1'b1;
                n.irq        = 1'b0;
                n.reset_seen = 1'b0;
            end else if (w == CMD_SETUP_READ) begin
                n.read_data  = {q.cur, q.chan};
                n.read_valid = 1'b1;
            end else if (w == CMD_FAULT_READ) begin
                n.read_data  = q.rec;
                n.read_valid = 1'b1;
            end else if (drv_ok) begin
                // Any accepted driver word ends an unbounded carrier.
                n.st = ST_IDLE;
                if (w[7:5] == OPC_SELECT) begin
                    n.bit_rate = w[SEL_RATE_BIT];
                    n.diag     = w[SEL_DIAG_BIT];
                    n.chan     = w[2:0];
                    if (w[SEL_DIAG_BIT]) begin
                        n.need_clear = 1'b1;
                    end
                end else if (w[7:5] == OPC_CURRENT) begin
                    n.cur = w[4:0];
                end else if (w[7:5] == OPC_CARRIER) begin
                    n.st          = ST_CARR;
                    n.car_left    = w[4:0];
                    n.car_endless = (w[4:0] == 5'h00);
                end else if (w[7:4] == OPC_DATA) begin
                    n.tel[0]      = w;
                    n.pay_left    = {1'b0, w[3:1]} + 4'h1;
                    n.pay_idx     = 4'h1;
                    n.pay_discard = 1'b0;
                    n.st          = ST_PAY;
                end
            end else if (!tx_busy && (w[7:4] == OPC_DATA)) begin
                // A telegram refused outside a transmission still swallows its payload words.
                n.pay_left    = {1'b0, w[3:1]} + 4'h1;
                n.pay_idx     = 4'h1;
                n.pay_discard = 1'b1;
                n.st          = ST_PAY;
            end
        end

        // Fault capture runs after the commands so that a new fault wins over
        // a clear or a status read in the same cycle.
        if (|fault_hit) begin
            if (n.rec[4:0] == 5'h00) begin
                n.rec[7:FR_CHAN_LSB] = q.chan;
            end
            n.rec[4:0] = n.rec[4:0] | fault_hit;
            n.irq      = 1'b1;
        end

        n.op = (&q.sup_s2) & (n.rec[4:0] == 5'h00) & ~n.need_clear & ~n.diag;
        if (!comm_ok || (!n.op && (n.st != ST_PAY))) begin
            n.st = ST_IDLE;
        end

        widx          = {1'b0, n.bit_cnt[5:3]} + 4'h1;
        n.coil_select = chan_onehot(n.chan);
        n.drive_enable = ((n.st == ST_DATA) || (n.st == ST_CARR)) & n.op;
        n.coil_drive  = n.drive_enable &
                        ((n.st == ST_CARR) | n.tel[widx][n.bit_cnt[2:0]]);
        n.pos_sw      = n.diag & n.cur[0];
        n.neg_sw      = n.diag & n.cur[1];
        n.gap         = (tx_busy && !bit_tick) ? q.gap + 12'h001 : 12'h000;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q             <= '0;
            q.st          <= ST_IDLE;
            q.chan        <= CHAN_RESET;
            q.bit_rate    <= RATE_RESET;
            q.diag        <= DIAG_RESET;
            q.cur         <= CUR_RESET;
            q.coil_select <= 6'h01;
            q.reset_seen  <= 1'b1;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.
    assign coil_select           = q.coil_select;
    assign drive_enable          = q.drive_enable;
    assign coil_drive            = q.coil_drive;
    assign current_step          = q.cur;
    assign line_diagnosis_enable = q.diag;
    assign pos_test_switch       = q.pos_sw;
    assign neg_test_switch       = q.neg_sw;
    assign read_valid            = q.read_valid;
    assign read_data             = q.read_data;
    assign operability_flag      = q.op;
    assign irq                   = q.irq;
    assign driver_fault_record   = q.rec;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_supply_low;
        !driver_supply_ok [*3];
    endsequence

    sequence s_carrier_start;
        word_new && (q.st != ST_PAY) && drv_ok && (w[7:5] == OPC_CARRIER) && n.op;
    endsequence

    property p_bit_length;
        bit_tick |-> (q.gap == (q.bit_rate ? FAST_GAP : NORM_GAP));
    endproperty
    a_bit_length: assert property (p_bit_length) else $error("bit length wrong");

    property p_diag_quiet;
        line_diagnosis_enable |-> !drive_enable && !coil_drive && !operability_flag;
    endproperty
    a_diag_quiet: assert property (p_diag_quiet) else $error("drive in diagnosis");

    property p_reset_setup;
        $fell(rst) |-> (coil_select == 6'h01) && !line_diagnosis_enable && !q.bit_rate;
    endproperty
    a_reset_setup: assert property (p_reset_setup) else $error("bad reset setup");

    property p_reset_current;
        $fell(rst) |-> (current_step == 5'h00);
    endproperty
    a_reset_current: assert property (p_reset_current) else $error("bad reset current");

    property p_fault_stops;
        (driver_fault_record[4:0] != 5'h00) |-> !drive_enable && !coil_drive &&
                                                !operability_flag;
    endproperty
    a_fault_stops: assert property (p_fault_stops) else $error("fault not handled");

    // The request itself may be cleared by a status read while the record stays.
    property p_irq_on_fault;
        (fault_hit != 5'h00) |=> irq;
    endproperty
    a_irq_on_fault: assert property (p_irq_on_fault) else $error("irq not raised");

    property p_record_kept;
        !clr_now |=> ((driver_fault_record & $past(driver_fault_record))
                      == $past(driver_fault_record));
    endproperty
    a_record_kept: assert property (p_record_kept) else $error("record lost");

    property p_status_clears;
        stat_now && (fault_hit == 5'h00) |=> !irq && read_valid;
    endproperty
    a_status_clears: assert property (p_status_clears) else $error("irq not cleared");

    property p_supply_low;
        s_supply_low |=> !operability_flag;
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("op kept on low supply");

    property p_carrier_on;
        s_carrier_start ##0 (fault_hit == 5'h00) |=> (drive_enable && coil_drive) [*2];
    endproperty
    a_carrier_on: assert property (p_carrier_on) else $error("carrier not driven");

    property p_test_switches;
        line_diagnosis_enable |-> (pos_test_switch == current_step[0]) &&
                                  (neg_test_switch == current_step[1]);
    endproperty
    a_test_switches: assert property (p_test_switches) else $error("bad test switch");

endmodule

// >>> dv/lfd_host_model.sv
/*
 * Host-side model: puts queued command words on the link, one per link cycle.
 * Assumes the bench pushes words into its queue and link_clk runs freely.
 */
`timescale 1ns/10ps
module lfd_host_model (
    // Link
    input  wire logic       link_clk,
    output logic            word_valid,
    output logic [7:0]      word_data
);
    logic [7:0] q[$];
    initial begin
        word_valid = 1'b0;
        word_data  = 8'h00;
    end
    // Idle data toggles, so a stale word can never pass for a fresh one.
    always @(negedge link_clk) begin
        if (q.size() > 0) begin
            word_valid <= 1'b1;
            word_data  <= q.pop_front();
        end else begin
            word_valid <= 1'b0;
            word_data  <= ~word_data;
        end
    end
endmodule

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the LF coil driver core.
 * Assumes the host model feeds the link and monitor inputs are levels.
 */
`timescale 1ns/10ps
module tb_top;
    import lfd_pkg::*;
    logic       mclk, link_clk, rst, sup_ok, word_valid, read_valid, op, irq;
    logic [7:0] word_data, read_data, rec, rd_last;
    logic [4:0] flt, cur_step;
    logic [5:0] coil;
    logic       drv_en, coil_drv, diag, pos_sw, neg_sw;
    int         err_total, checked, cyc, n, g, i, cur, k, d;

    lfd_host_model host (.link_clk(link_clk), .word_valid(word_valid), .word_data(word_data));
    lfd_core dut (.mclk(mclk), .rst(rst), .link_clk(link_clk), .word_valid(word_valid),
        .word_data(word_data), .oscillator_stable(1'b1), .analog_supply_ok(1'b1),
        .driver_supply_ok(sup_ok), .thermal_shutdown(flt[4]), .missing_return_fault(flt[3]),
        .shunt_overvoltage_fault(flt[2]), .high_side_overcurrent_fault(flt[1]),
        .low_side_overcurrent_fault(flt[0]), .coil_select(coil), .drive_enable(drv_en),
        .coil_drive(coil_drv), .current_step(cur_step), .line_diagnosis_enable(diag),
        .pos_test_switch(pos_sw), .neg_test_switch(neg_sw), .read_valid(read_valid),
        .read_data(read_data), .operability_flag(op), .irq(irq), .driver_fault_record(rec));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (read_valid === 1'b1) rd_last <= read_data;
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The link side needs a few link cycles before the effect reaches mclk.
    task automatic send(input logic [7:0] w);
        host.q.push_back(w);
        repeat (4) @(posedge link_clk);
        @(negedge mclk);
    endtask
    task automatic pulse_len(output int len);
        len = 0;
        for (int t = 0; t < 300 && drv_en !== 1'b1; t++) @(negedge mclk);
        while (drv_en === 1'b1 && len < 5000) begin
            @(negedge mclk);
            len++;
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; sup_ok = 1'b1; flt = 5'h00; cyc = 0; err_total = 0; checked = 0;
        void'($urandom(32'hFCC6));
        // Reset spans several link cycles so the link side resets too.
        repeat (70) @(negedge mclk);
        rst = 1'b0;
        repeat (10) @(posedge link_clk);
        @(negedge mclk);
        chk({coil, diag, cur_step}, {6'h01, 1'b0, 5'h00});
        chk({rec, irq, op}, {8'h00, 1'b0, 1'b1});
        send(CMD_SETUP_READ);
        chk(rd_last, 8'h01);
        g = $urandom % 2;
        i = $urandom % 3 + 1;
        cur = $urandom % 20;
        send({3'h1, 2'b00, g[0], i[1:0]});
        chk(coil, 6'h01 << (g * 3 + i - 1));
        send({3'h5, cur[4:0]});
        chk(cur_step, cur);
        send(CMD_SETUP_READ);
        chk(rd_last, {cur[4:0], g[0], i[1:0]});
        for (k = 0; k < 2; k++) begin
            send({3'h1, k[0], 1'b0, g[0], i[1:0]});
            host.q.push_back(8'h81);
            pulse_len(n);
            chk(n, k ? 1408 : 2048);
        end
        send({3'h1, 2'b00, g[0], i[1:0]});
        send(8'hA0);
        for (k = 0; k < 5; k++) begin
            send(8'h80);
            chk({drv_en, coil_drv}, 2'b11);
            flt[k] = 1'b1;
            repeat (8) @(negedge mclk);
            chk({drv_en, irq}, 2'b01);
            chk(rec, {g[0], i[1:0], 5'h01 << k});
            flt = 5'h00;
            send(CMD_STATUS_READ);
            chk({irq, rec}, {1'b0, g[0], i[1:0], 5'h01 << k});
            chk(rd_last, {k == 0, 1'b1, 2'b00, k == 4, 3'b000});
            send(CMD_FAULT_READ);
            chk(rd_last, {g[0], i[1:0], 5'h01 << k});
            send(CMD_FAULT_CLEAR);
            chk({rec, op}, {8'h00, 1'b1});
        end
        send({3'h5, 5'h03});
        send({3'h1, 2'b01, g[0], i[1:0]});
        chk({diag, pos_sw, neg_sw}, 3'b111);
        send(8'h81);
        chk(drv_en, 1'b0);
        send({3'h1, 2'b00, g[0], i[1:0]});
        chk({diag, op}, 2'b00);
        send(CMD_FAULT_CLEAR);
        chk(op, 1'b1);
        sup_ok = 1'b0;
        repeat (8) @(negedge mclk);
        chk(op, 1'b0);
        send(8'h81);
        chk(drv_en, 1'b0);
        sup_ok = 1'b1;
        repeat (8) @(negedge mclk);
        chk(op, 1'b1);
        // Three nibbles: header 02 and two whole words, upper nibble of the last unused.
        d = $urandom;
        send(8'h02);
        host.q.push_back(d[7:0]);
        host.q.push_back(d[15:8]);
        for (int t = 0; t < 600 && drv_en !== 1'b1; t++) @(negedge mclk);
        repeat (1024) @(negedge mclk);
        for (k = 0; k < 12; k++) begin
            chk(coil_drv, d[k]);
            repeat (2048) @(negedge mclk);
        end
        chk(drv_en, 1'b0);
        wrap_up();
    end
endmodule
